// File: dpo_freq_det.sv
// frequency detector referenced to the training clock
`default_nettype none
module dpo_freq_det (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_resetn,
    // training clock pin
    input  wire logic i_cdr_training_clock,
    // lock indication
    output logic      o_lock
);
    logic       sync1;
    logic       sync2;
    logic       sync3;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [2:0] good;
    logic [2:0] next_good;
    logic       rise;

    assign rise = sync2 & ~sync3;

    always_comb begin
        next_count = count;
        next_good  = good;
        if (rise) begin
            next_count = 8'h01;
            if (count >= dpo_pkg::TRG_MIN_CYC &&
                count <= dpo_pkg::TRG_MAX_CYC) begin
                if (good != dpo_pkg::LOCK_GOOD_CNT) begin
                    next_good = good + 3'h1;
                end
            end else begin
                next_good = 3'h0;
            end
        end else if (count >= dpo_pkg::TRG_TIMEOUT_CYC) begin
            // stopped training clock drops lock
            next_good = 3'h0;
        end else begin
            next_count = count + 8'h01;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1  <= 1'b0;
            sync2  <= 1'b0;
            sync3  <= 1'b0;
            count  <= 8'h00;
            good   <= 3'h0;
            o_lock <= 1'b0;
        end else begin
            sync1  <= i_cdr_training_clock;
            sync2  <= sync1;
            sync3  <= sync2;
            count  <= next_count;
            good   <= next_good;
            o_lock <= (next_good == dpo_pkg::LOCK_GOOD_CNT);
        end
    end
endmodule
`default_nettype wire

// File: dpo_host_model.sv
// host logic capturing characters on forwarded clock edges
`default_nettype none
module dpo_host_model (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // channel mode as programmed
    input  wire logic       i_half,
    input  wire logic [1:0] i_sel,
    // parallel receive interface
    input  wire logic       i_fclk,
    input  wire logic [9:0] i_char,
    input  wire logic       i_pin,
    // captured values
    output logic      [9:0] o_char,
    output logic            o_pin,
    output logic      [7:0] o_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev;
    logic cap;
    // edge seen one cycle late; data stands a whole period so this is safe
    assign cap = (i_fclk && !prev) || (i_half && !i_fclk && prev);
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prev    <= 1'b0;
            o_char  <= 10'h000;
            o_pin   <= 1'b0;
            o_count <= 8'h00;
        end else begin
            prev <= i_fclk;
            if (cap) begin
                o_count <= o_count + 8'h01;
                o_char  <= (i_sel != 2'h0) ? {8'h00, i_char[1:0]}
                                           : i_char;
                o_pin   <= (i_sel == 2'h2) && i_pin;
            end
        end
    end
endmodule
`default_nettype wire

// File: dpo_pkg.sv
// constants shared by the parallel receive output block
`default_nettype none
package dpo_pkg;
    // reference clock and training clock timing
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          TRG_PERIOD_NS   = 125;
    localparam int          TRG_NOM_CYC     = TRG_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0]  TRG_MIN_CYC     = 8'(TRG_NOM_CYC - 1);
    localparam logic [7:0]  TRG_MAX_CYC     = 8'(TRG_NOM_CYC + 2);
    localparam logic [7:0]  TRG_TIMEOUT_CYC = 8'(4 * TRG_NOM_CYC);
    localparam logic [2:0]  LOCK_GOOD_CNT   = 3'h4;

    // one recovered character every CHAR_PERIOD_CYC reference cycles
    localparam logic [4:0]  CHAR_PERIOD_CYC = 5'h0A;
    localparam logic [4:0]  CHAR_HALF_CYC   = 5'h05;

    // register map, byte addresses
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_STATUS     = 4'h4;
    localparam logic [3:0]  ADDR_MASK       = 4'h8;
    localparam logic [3:0]  ADDR_STATE      = 4'hC;

    // control register fields
    localparam int          CTRL_RATE_BIT   = 0;
    localparam int          CTRL_ROE1_BIT   = 1;
    localparam int          CTRL_ROE2_BIT   = 2;
    localparam int          CTRL_SEL_LSB    = 3;
    localparam int          CTRL_W          = 5;
    localparam logic [4:0]  CTRL_RESET      = 5'h06;

    // event bits of status and mask
    localparam int          EV_LOCK_CHG     = 0;
    localparam int          EV_BIST_ERR     = 1;
    localparam int          EV_PDOWN_CHG    = 2;
    localparam int          EV_W            = 3;
    localparam logic [2:0]  EV_RESET        = 3'h0;

    // self-test select values: off, and the one that makes the status pin valid
    localparam logic [1:0]  SEL_OFF         = 2'h0;
    localparam logic [1:0]  SEL_VALID       = 2'h2;

    // checker report {status pin, bit1, bit0}
    localparam logic [2:0]  BIST_WAIT       = 3'h0;
    localparam logic [2:0]  BIST_GOOD       = 3'h1;
    localparam logic [2:0]  BIST_BAD        = 3'h6;

    typedef enum logic [0:0] {DPO_BIST_HUNT, DPO_BIST_RUN} dpo_bist_state_t;
endpackage
`default_nettype wire

// File: dpo_properties.sv
// port assertions for one receive channel
`default_nettype none
module dpo_properties (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    // design inputs
    input  wire logic        i_char_valid,
    input  wire logic [9:0]  i_char_data,
    input  wire logic        i_cdr_training_clock,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    // design outputs
    input  wire logic [31:0] o_rdata,
    input  wire logic [9:0]  o_recovered_char_out,
    input  wire logic        o_forwarded_rx_clock,
    input  wire logic        o_forwarded_rx_clock_n,
    input  wire logic        o_selftest_status_pin,
    input  wire logic        o_reclocker_off_flag,
    input  wire logic        o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] calm;
    logic [4:0] next_calm;
    logic [4:0] ctl;
    logic [4:0] next_ctl;
    logic       ok;
    logic       fclk;
    // mode checks wait out a mode change; mid-period switches are not judged
    always_comb begin
        next_calm = (calm == 5'h1F) ? calm : calm + 5'h01;
        next_ctl  = ctl;
        if (i_wr && i_addr == 4'h0) begin
            next_calm = 5'h00;
            next_ctl  = i_wdata[4:0];
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            calm <= 5'h1F;
            ctl  <= dpo_pkg::CTRL_RESET;
        end else begin
            calm <= next_calm;
            ctl  <= next_ctl;
        end
    end
    assign ok   = calm > 5'h13;
    assign fclk = o_forwarded_rx_clock;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    a_char_on_edge: assert property (disable iff (!i_resetn || !ok)
        $changed(o_recovered_char_out) |-> $changed(fclk))
        else $error("char changed without clock edge");
    a_full_rise: assert property (disable iff (!i_resetn || !ok)
        !ctl[0] && $changed(o_recovered_char_out) |-> $rose(fclk))
        else $error("full rate char not on rising edge");
    a_full_period: assert property (disable iff (!i_resetn || !ok)
        !ctl[0] && $rose(fclk) |-> ##5 $fell(fclk) ##5 $rose(fclk))
        else $error("full rate clock period wrong");
    a_half_period: assert property (disable iff (!i_resetn || !ok)
        ctl[0] && $changed(fclk) |-> ##2 $stable(fclk)[*8] ##1 $changed(fclk))
        else $error("half rate clock period wrong");
    a_clk_compl: assert property (
        o_forwarded_rx_clock_n == !fclk)
        else $error("clock pair not complementary");
    a_off_set: assert property (
        i_wr && i_addr == 4'h0 && i_wdata[2:1] == 2'h0
        |-> ##[1:2] o_reclocker_off_flag)
        else $error("off flag not raised");
    a_off_clear: assert property (
        i_wr && i_addr == 4'h0 && i_wdata[2:1] != 2'h0
        |-> ##[1:2] !o_reclocker_off_flag)
        else $error("off flag not cleared");
    a_bist_upper: assert property (disable iff (!i_resetn || !ok)
        ctl[4:3] != 2'h0 |-> o_recovered_char_out[9:2] == 8'h00)
        else $error("upper bits not quiet in self-test");
    a_pin_gated: assert property (disable iff (!i_resetn || !ok)
        ctl[4:3] != 2'h2 |-> !o_selftest_status_pin)
        else $error("status pin high with wrong select");

    c_full_rise: cover property (!ctl[0] && ok && $rose(fclk));
    c_half_edge: cover property (ctl[0] && ok && $fell(fclk));
    c_pin_high: cover property (o_selftest_status_pin);
endmodule
bind dpo_top dpo_properties u_chk (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_char_valid(i_char_valid), .i_char_data(i_char_data),
    .i_cdr_training_clock(i_cdr_training_clock),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_recovered_char_out(o_recovered_char_out),
    .o_forwarded_rx_clock(o_forwarded_rx_clock),
    .o_forwarded_rx_clock_n(o_forwarded_rx_clock_n),
    .o_selftest_status_pin(o_selftest_status_pin),
    .o_reclocker_off_flag(o_reclocker_off_flag), .o_irq(o_irq));
`default_nettype wire

// File: dpo_selftest.sv
// self-test pattern checker on recovered characters
`default_nettype none
module dpo_selftest (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_resetn,
    // character stream
    input  wire logic       i_enable,
    input  wire logic       i_char_strobe,
    input  wire logic [9:0] i_char,
    // checker report
    output logic      [2:0] o_status,
    output logic            o_error
);
    dpo_pkg::dpo_bist_state_t state;
    dpo_pkg::dpo_bist_state_t next_state;
    logic [9:0] prev;
    logic [9:0] next_prev;
    logic [2:0] next_status;
    logic       next_error;

    // expected successor of a character in the test sequence
    function automatic logic [9:0] dpo_step(input logic [9:0] c);
        dpo_step = {c[8:0], c[9] ^ c[6]};
    endfunction

    always_comb begin
        next_state  = state;
        next_prev   = prev;
        next_status = o_status;
        next_error  = 1'b0;
        if (!i_enable) begin
            next_state  = dpo_pkg::DPO_BIST_HUNT;
            next_status = dpo_pkg::BIST_WAIT;
        end else if (i_char_strobe) begin
            next_prev = i_char;
            case (state)
                dpo_pkg::DPO_BIST_HUNT: begin
                    // an all-zero word never occurs in the sequence
                    if (i_char != 10'h000) begin
                        next_state = dpo_pkg::DPO_BIST_RUN;
                    end
                end
                dpo_pkg::DPO_BIST_RUN: begin
                    if (i_char == dpo_step(prev)) begin
                        next_status = dpo_pkg::BIST_GOOD;
                    end else begin
                        next_status = dpo_pkg::BIST_BAD;
                        next_error  = 1'b1;
                    end
                end
                default: next_state = dpo_pkg::DPO_BIST_HUNT;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state    <= dpo_pkg::DPO_BIST_HUNT;
            prev     <= 10'h000;
            o_status <= dpo_pkg::BIST_WAIT;
            o_error  <= 1'b0;
        end else begin
            state    <= next_state;
            prev     <= next_prev;
            o_status <= next_status;
            o_error  <= next_error;
        end
    end
endmodule
`default_nettype wire

// File: dpo_top.sv
// one receive channel: parallel character output, clocks and status
//
// Summary of operation
// [RL1] character output changes only with forwarded clock
// [RL2] full rate: data on rising true edge
// [RL3] half rate: data on both clock edges
// [RL4] self-test shows checker state on bits 1:0
// [RL5] host ignores upper bits during self-test
// [RL6] status pin valid only when select is 10
// [RL7] off flag high when both enables zero
// [RL8] training clock references the frequency detector
// [RL9] forwarded clock runs continuously at chosen rate
// [RL10] host captures in each channel's clock domain; the host model samples the forwarded clock on the reference clock
`default_nettype none
module dpo_top (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    // recovered characters from the deserializer
    input  wire logic        i_char_valid,
    input  wire logic [9:0]  i_char_data,
    // training clock pin
    input  wire logic        i_cdr_training_clock,
    // register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // parallel receive interface
    output logic      [9:0]  o_recovered_char_out,
    output logic             o_forwarded_rx_clock,
    output logic             o_forwarded_rx_clock_n,
    output logic             o_selftest_status_pin,
    // status
    output logic             o_reclocker_off_flag,
    output logic             o_irq
);
    // control and interrupt registers
    logic [dpo_pkg::CTRL_W-1:0] ctrl;
    logic [dpo_pkg::CTRL_W-1:0] next_ctrl;
    logic [dpo_pkg::EV_W-1:0]   status;
    logic [dpo_pkg::EV_W-1:0]   next_status;
    logic [dpo_pkg::EV_W-1:0]   mask;
    logic [dpo_pkg::EV_W-1:0]   next_mask;
    logic [31:0]                next_rdata;
    logic [dpo_pkg::EV_W-1:0]   events;
    logic [dpo_pkg::EV_W-1:0]   clear;

    // character path
    logic [9:0] held;
    logic [9:0] next_held;
    logic [4:0] phase;
    logic [4:0] next_phase;
    logic [9:0] next_char_out;
    logic       next_fclk;
    logic       next_stat_pin;
    logic       next_off;
    logic       lock_d;
    logic       off_d;

    // decoded control fields
    logic       half_rate;
    logic       roe1;
    logic       roe2;
    logic [1:0] sel;
    logic       selftest_on;
    logic       tick;
    logic       lock;
    logic       accept;
    logic [2:0] bist_status;
    logic       bist_error;

    assign half_rate   = ctrl[dpo_pkg::CTRL_RATE_BIT];
    assign roe1        = ctrl[dpo_pkg::CTRL_ROE1_BIT];
    assign roe2        = ctrl[dpo_pkg::CTRL_ROE2_BIT];
    assign sel         = ctrl[dpo_pkg::CTRL_SEL_LSB +: 2];
    assign selftest_on = (sel != dpo_pkg::SEL_OFF);
    assign tick        = (phase == 5'h00);

    // last phase of a character period, wraps back to the tick
    localparam logic [4:0] CHAR_LAST = dpo_pkg::CHAR_PERIOD_CYC - 5'h01;
    // characters are trusted only once the loop has acquired
    assign accept      = i_char_valid & lock;

    // recovery loop lock, referenced to the training clock
    dpo_freq_det u_freq_det (
        .i_ref_clk            (i_ref_clk),
        .i_resetn             (i_resetn),
        .i_cdr_training_clock (i_cdr_training_clock), // [RL8]
        .o_lock               (lock)
    );

    dpo_selftest u_selftest (
        .i_ref_clk     (i_ref_clk),
        .i_resetn      (i_resetn),
        .i_enable      (selftest_on),
        .i_char_strobe (accept),
        .i_char        (i_char_data),
        .o_status      (bist_status),
        .o_error       (bist_error)
    );

    // register file
    always_comb begin
        next_ctrl  = ctrl;
        next_mask  = mask;
        next_rdata = 32'h0000_0000;
        clear      = '0;
        if (i_wr) begin
            case (i_addr)
                dpo_pkg::ADDR_CTRL:   next_ctrl = i_wdata[dpo_pkg::CTRL_W-1:0];
                dpo_pkg::ADDR_STATUS: clear     = i_wdata[dpo_pkg::EV_W-1:0];
                dpo_pkg::ADDR_MASK:   next_mask = i_wdata[dpo_pkg::EV_W-1:0];
                default:              next_ctrl = ctrl;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                dpo_pkg::ADDR_CTRL:   next_rdata[dpo_pkg::CTRL_W-1:0] = ctrl;
                dpo_pkg::ADDR_STATUS: next_rdata[dpo_pkg::EV_W-1:0]   = status;
                dpo_pkg::ADDR_MASK:   next_rdata[dpo_pkg::EV_W-1:0]   = mask;
                dpo_pkg::ADDR_STATE:
                    next_rdata[4:0] = {bist_status, o_reclocker_off_flag, lock};
                default:              next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    always_comb begin
        events = '0;
        events[dpo_pkg::EV_LOCK_CHG]  = lock ^ lock_d;
        events[dpo_pkg::EV_BIST_ERR]  = bist_error;
        events[dpo_pkg::EV_PDOWN_CHG] = o_reclocker_off_flag ^ off_d;
        next_status = (status & ~clear) | events;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl    <= dpo_pkg::CTRL_RESET;
            status  <= dpo_pkg::EV_RESET;
            mask    <= dpo_pkg::EV_RESET;
            o_rdata <= 32'h0000_0000;
            lock_d  <= 1'b0;
            off_d   <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            status  <= next_status;
            mask    <= next_mask;
            o_rdata <= next_rdata;
            lock_d  <= lock;
            off_d   <= o_reclocker_off_flag;
        end
    end

    assign o_irq = |(status & mask);

    // character timing and forwarded clock
    always_comb begin
        next_held     = accept ? i_char_data : held;
        next_phase    = (phase == CHAR_LAST) ? 5'h00 : phase + 5'h01;
        next_char_out = o_recovered_char_out;
        next_fclk     = o_forwarded_rx_clock;
        next_stat_pin = o_selftest_status_pin;
        // reclocker serial outputs powered down
        next_off      = ~roe1 & ~roe2; // [RL7]
        // clock never stops, only its rate follows the rate bit
        if (half_rate) begin
            if (tick) begin
                next_fclk = ~o_forwarded_rx_clock; // [RL3] [RL9]
            end
        end else if (tick) begin
            next_fclk = 1'b1; // [RL2] [RL9]
        end else if (phase == dpo_pkg::CHAR_HALF_CYC) begin
            next_fclk = 1'b0;
        end
        // data moves in the same edge as the clock, never between
        if (tick) begin
            if (selftest_on) begin
                // upper bits carry nothing while the checker owns the pins
                next_char_out = {8'h00, bist_status[1:0]}; // [RL4] [RL5]
            end else begin
                next_char_out = held; // [RL1]
            end
            // pin only meaningful for the valid select code
            next_stat_pin = (sel == dpo_pkg::SEL_VALID)
                            & bist_status[2]; // [RL6]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            held                  <= 10'h000;
            phase                 <= 5'h00;
            o_recovered_char_out  <= 10'h000;
            o_forwarded_rx_clock  <= 1'b0;
            o_selftest_status_pin <= 1'b0;
            o_reclocker_off_flag  <= 1'b0;
        end else begin
            held                  <= next_held;
            phase                 <= next_phase;
            o_recovered_char_out  <= next_char_out;
            o_forwarded_rx_clock  <= next_fclk;
            o_selftest_status_pin <= next_stat_pin;
            o_reclocker_off_flag  <= next_off;
        end
    end

    // complement leg of the clock pair
    assign o_forwarded_rx_clock_n = ~o_forwarded_rx_clock;
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for one receive channel
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
    $display("Error at %0t: got %h want %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cval = 1'b0;
    logic [9:0]  cdat = 10'h000;
    logic        trg = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        half = 1'b0;
    logic [1:0]  sel = 2'h0;
    logic [31:0] rdat;
    logic [9:0]  rchar;
    logic        fclk;
    logic        fclk_n;
    logic        pin;
    logic        off;
    logic        irq;
    logic [9:0]  hchar;
    logic        hpin;
    logic [7:0]  hcnt;
    logic [31:0] v;
    logic [9:0]  c;
    int          miscompares = 0;
    int          checked = 0;

    always #5 clk = ~clk;
    initial begin
        #3.3;
        forever #62.5 trg = ~trg;
    end

    dpo_top i_dut (.i_ref_clk(clk), .i_resetn(rst_n), .i_char_valid(cval),
        .i_char_data(cdat), .i_cdr_training_clock(trg), .i_addr(addr),
        .i_wdata(wdat), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
        .o_recovered_char_out(rchar), .o_forwarded_rx_clock(fclk),
        .o_forwarded_rx_clock_n(fclk_n), .o_selftest_status_pin(pin),
        .o_reclocker_off_flag(off), .o_irq(irq));
    dpo_host_model i_host (.i_clk(clk), .i_resetn(rst_n), .i_half(half),
        .i_sel(sel), .i_fclk(fclk), .i_char(rchar), .i_pin(pin),
        .o_char(hchar), .o_pin(hpin), .o_count(hcnt));

    task automatic print_verdict;
        $display("mismatches %0d of %0d checks", miscompares, checked);
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask
    task automatic wr_ctl(input logic [31:0] d);
        wr_reg(4'h0, d);
        half <= d[0];
        sel <= d[4:3];
        repeat (25) @(posedge clk);
    endtask
    task automatic next_cap;
        logic [7:0] n0;
        n0 = hcnt;
        for (int i = 0; i < 40 && hcnt == n0; i++) @(posedge clk);
        if (hcnt == n0) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic send(input logic [9:0] d);
        next_cap();
        @(posedge clk);
        cval <= 1'b1;
        cdat <= d;
        @(posedge clk);
        cval <= 1'b0;
    endtask
    function automatic logic [9:0] lfsr(input logic [9:0] p);
        return {p[8:0], p[9] ^ p[6]};
    endfunction

    initial begin
        void'($urandom(17442));
        repeat (12) @(posedge clk);
        `CHK(fclk_n, 1'b1)
        `CHK(rchar, 10'h000)
        rst_n <= 1'b1;
        rd_reg(4'h0, v);
        `CHK(v, 32'h6)
        `CHK(off, 1'b0)
        rd_reg(4'h2, v);
        `CHK(v, 32'h0)
        v = 32'h0;
        for (int i = 0; i < 80 && v[0] !== 1'b1; i++) rd_reg(4'hC, v);
        `CHK(v[0], 1'b1)
        // full rate first, then half rate, corner values lead
        for (int m = 0; m < 2; m++) begin
            wr_ctl(32'(6 + m));
            for (int k = 0; k < 8; k++) begin
                c = (k < 2) ? {10{k[0]}} : 10'($urandom);
                send(c);
                next_cap();
                `CHK(hchar, c)
            end
        end
        wr_reg(4'h4, 32'h7);
        wr_reg(4'h8, 32'h0);
        wr_ctl(32'h0);
        `CHK(off, 1'b1)
        rd_reg(4'h4, v);
        `CHK(v, 32'h4)
        `CHK(irq, 1'b0)
        wr_reg(4'h8, 32'h4);
        #1 `CHK(irq, 1'b1)
        wr_reg(4'h4, 32'h4);
        #1 `CHK(irq, 1'b0)
        wr_ctl(32'h6);
        `CHK(off, 1'b0)
        wr_ctl(32'h16);
        c = 10'($urandom) | 10'h001;
        for (int k = 0; k < 6; k++) begin
            send(c);
            c = lfsr(c);
        end
        next_cap();
        `CHK(hchar, 10'h001)
        `CHK(hpin, 1'b0)
        send(~c);
        next_cap();
        `CHK(hchar, 10'h002)
        `CHK(hpin, 1'b1)
        `CHK(rchar[9:2], 8'h00)
        wr_ctl(32'h0E);
        `CHK(pin, 1'b0)
        print_verdict();
    end
endmodule
`default_nettype wire
